// file: shared/ts_record_pkg.sv
// ****************************************************************
// timestamp record register constants and carrier types
// ****************************************************************
package ts_record_pkg;

  // ****************************************************************
  // register map: printed offsets are register indices
  // ****************************************************************
  localparam int        NUM_REGS        = 8;
  localparam int        APB_ADDR_W      = 12;
  localparam logic [7:0] IDX_R1_MINUTES = 8'h2a; // record1_minutes
  localparam logic [7:0] IDX_R1_HOURS   = 8'h2b; // record1_hours
  localparam logic [7:0] IDX_R1_DAY     = 8'h2c; // record1_day_of_month
  localparam logic [7:0] IDX_R1_MONTH   = 8'h2d; // record1_month_century
  localparam logic [7:0] IDX_R1_YEAR    = 8'h2e; // record1_year
  localparam logic [7:0] IDX_R1_TRIGGER = 8'h2f; // record1_trigger_source
  localparam logic [7:0] IDX_R2_SUBSEC  = 8'h30; // record2_subsecond
  localparam logic [7:0] IDX_R2_SECONDS = 8'h31; // record2_seconds
  localparam logic [7:0] IDX_BASE       = IDX_R1_MINUTES;
  localparam logic [7:0] IDX_LAST       = IDX_R2_SECONDS;

  // ****************************************************************
  // local slot numbers inside the register array
  // ****************************************************************
  localparam logic [2:0] SLOT_MIN     = 3'h0;
  localparam logic [2:0] SLOT_HOUR    = 3'h1;
  localparam logic [2:0] SLOT_DATE    = 3'h2;
  localparam logic [2:0] SLOT_MONTH   = 3'h3;
  localparam logic [2:0] SLOT_YEAR    = 3'h4;
  localparam logic [2:0] SLOT_TRIGGER = 3'h5;
  localparam logic [2:0] SLOT_SUBSEC  = 3'h6;
  localparam logic [2:0] SLOT_SEC     = 3'h7;

  // ****************************************************************
  // reset value and writable bits per slot (reserved read zero)
  // ****************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] WR_MASK [NUM_REGS] = '{
    8'h7f, 8'h7f, 8'h3f, 8'h9f, 8'hff, 8'h0f, 8'h7f, 8'h7f};

  // ****************************************************************
  // hour byte fields
  // ****************************************************************
  localparam int HOUR_MODE_BIT         = 6; // set: 12-hour counting
  localparam int HOUR_TWENTY_OR_PM_BIT = 5; // pm flag or bcd 20
  localparam int HOUR_TENS_DIGIT_BIT   = 4; // bcd 10

  // ****************************************************************
  // trigger-source flag bits
  // ****************************************************************
  localparam int LOW_BACKUP_TRIGGER_FLAG_BIT  = 3;
  localparam int TO_BACKUP_TRIGGER_FLAG_BIT   = 2;
  localparam int TO_MAIN_TRIGGER_FLAG_BIT     = 1;
  localparam int EVENT_INPUT_TRIGGER_FLAG_BIT = 0;

  // ****************************************************************
  // bcd range checks: slot, tens mask, largest value
  // ****************************************************************
  localparam int        NUM_BCD = 5;
  localparam logic [2:0] BCD_SLOT [NUM_BCD] = '{
    SLOT_MIN, SLOT_SEC, SLOT_DATE, SLOT_MONTH, SLOT_YEAR};
  localparam logic [3:0] BCD_TENS_MASK [NUM_BCD] = '{
    4'h7, 4'h7, 4'h3, 4'h1, 4'hf};
  localparam logic [7:0] BCD_MAX [NUM_BCD] = '{
    8'h3b, 8'h3b, 8'h1f, 8'h0c, 8'h63};

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] subsec; // binary fraction, bit 6 = 1/2 s
    logic [7:0] sec;    // bcd seconds
    logic [7:0] min;    // bcd minutes
    logic [7:0] hour;   // hour byte
    logic [7:0] date;   // bcd day of month
    logic [7:0] month;  // century and bcd month
    logic [7:0] year;   // bcd year
  } time_snapshot_t;

  typedef struct packed {
    logic low_backup;  // low backup voltage detected
    logic to_backup;   // main to backup switchover
    logic to_main;     // backup to main switchover
    logic event_input; // digital event input edge
  } trigger_src_t;

  typedef struct packed {
    logic       mode12;  // 12-hour counting
    logic       pm;      // afternoon in 12-hour counting
    logic [4:0] hour24;  // hour as 0..23 binary
    logic       ok;      // byte is a legal hour
  } hour_info_t;

endpackage

// file: rtl/ts_hour_decode.sv
`timescale 1ns/1ps
// ****************************************************************
// hour byte decoder
// ****************************************************************
module ts_hour_decode (
  // stored hour byte
  input  wire logic [7:0]                  hour_byte_i,
  // decoded view
  output ts_record_pkg::hour_info_t         info_o
);

  logic [3:0] units;   // units-of-hours digit
  logic [5:0] base;    // tens plus units
  logic [5:0] sum24;   // base plus twenty weight

  // ****************************************************************
  // decode 12/24 hour formats
  // ****************************************************************
  always_comb begin
    units = hour_byte_i[3:0];
    base  = {2'b00, units} + (hour_byte_i[ts_record_pkg::HOUR_TENS_DIGIT_BIT]
            ? 6'h0a : 6'h00);
    sum24 = base + (hour_byte_i[ts_record_pkg::HOUR_TWENTY_OR_PM_BIT]
            ? 6'h14 : 6'h00);
    info_o.mode12 = hour_byte_i[ts_record_pkg::HOUR_MODE_BIT];
    info_o.pm     = hour_byte_i[ts_record_pkg::HOUR_MODE_BIT]
                  & hour_byte_i[ts_record_pkg::HOUR_TWENTY_OR_PM_BIT];
    if (hour_byte_i[ts_record_pkg::HOUR_MODE_BIT]) begin
      // 12-hour: 1..12, bit 5 is pm
      info_o.ok = (units <= 4'h9) && (base >= 6'h01) && (base <= 6'h0c);
      if (info_o.ok) begin
        info_o.hour24 = 5'((base == 6'h0c ? 6'h00 : base)
                      + (info_o.pm ? 6'h0c : 6'h00));
      end else begin
        info_o.hour24 = 5'h00;
      end
    end else begin
      // 24-hour: 0..23, bit 5 weighs twenty
      info_o.ok = (units <= 4'h9) && (sum24 <= 6'h17)
                && !(hour_byte_i[5] && hour_byte_i[4]);
      info_o.hour24 = info_o.ok ? sum24[4:0] : 5'h00;
    end
  end

endmodule // ts_hour_decode

// file: rtl/ts_bcd_check.sv
`timescale 1ns/1ps
// ****************************************************************
// bcd field range checker
// ****************************************************************
module ts_bcd_check #(
  parameter logic [3:0] TENS_MASK = 4'h7, // valid tens bits
  parameter logic [7:0] MAX_VALUE = 8'h3b // largest legal value
) (
  // stored field byte
  input  wire logic [7:0] field_i,
  // range result
  output logic            ok_o
);

  logic [7:0] binary; // tens*10 + units

  // ****************************************************************
  // digit and range check
  // ****************************************************************
  always_comb begin
    binary = 8'(field_i[7:4] & TENS_MASK) * 8'h0a + {4'h0, field_i[3:0]};
    ok_o   = (field_i[3:0] <= 4'h9) && (binary <= MAX_VALUE);
  end

endmodule // ts_bcd_check

// file: rtl/ts_record_regs.sv
`timescale 1ns/1ps
module ts_record_regs (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_n_i,
  // apb slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [11:0]                   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic                               pready_o,
  output logic [31:0]                        prdata_o,
  output logic                               pslverr_o,
  // capture from timekeeping logic, same clock
  input  wire logic                          capture1_i,
  input  wire logic                          capture2_i,
  input  wire ts_record_pkg::time_snapshot_t snapshot_i,
  input  wire ts_record_pkg::trigger_src_t   source_i,
  // stored bytes and decoded views
  output logic [7:0][7:0]                    record_bytes_o,
  output ts_record_pkg::hour_info_t          hour_info_o,
  output logic [4:0]                         bcd_ok_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0][7:0]           rec;     // stored record bytes
    logic                      pready;  // access answer
    logic                      pslverr; // unmapped access
    logic [31:0]               prdata;  // latched read data
    ts_record_pkg::hour_info_t hour;    // decoded hour view
    logic [4:0]                bcd_ok;  // bcd checks per field
  } ts_state_t;

  ts_state_t  state_reg;               // registered state
  ts_state_t  state_next;              // next state
  ts_record_pkg::hour_info_t hour_dec; // decoder result
  logic [4:0] bcd_dec;                 // checker results
  logic [7:0] addr_idx;                // word index of address
  logic [2:0] slot;                    // slot inside the array
  logic       addr_hit;                // address maps a register
  logic       access;                  // apb access phase
  logic       wr_fire;                 // write takes effect
  logic [7:0] wr_slot_hit;             // one-hot write target

  // ****************************************************************
  // address decode
  // ****************************************************************
  always_comb begin
    addr_idx = paddr_i[9:2];
    addr_hit = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0)
             && (addr_idx >= ts_record_pkg::IDX_BASE)
             && (addr_idx <= ts_record_pkg::IDX_LAST);
    slot     = 3'(addr_idx - ts_record_pkg::IDX_BASE);
    access   = psel_i && penable_i;
    // write lands on the edge where pready is seen high
    wr_fire  = access && state_reg.pready && pwrite_i && addr_hit;
  end

  // ****************************************************************
  // per-slot write strobes
  // ****************************************************************
  for (genvar g = 0; g < ts_record_pkg::NUM_REGS; g++) begin : g_wr
    assign wr_slot_hit[g] = wr_fire && (slot == 3'(g));
  end

  // ****************************************************************
  // decoders
  // ****************************************************************
  ts_hour_decode u_hour (
    .hour_byte_i (state_reg.rec[ts_record_pkg::SLOT_HOUR]),
    .info_o      (hour_dec)
  );

  for (genvar b = 0; b < ts_record_pkg::NUM_BCD; b++) begin : g_bcd
    ts_bcd_check #(
      .TENS_MASK (ts_record_pkg::BCD_TENS_MASK[b]),
      .MAX_VALUE (ts_record_pkg::BCD_MAX[b])
    ) u_check (
      .field_i (state_reg.rec[ts_record_pkg::BCD_SLOT[b]]),
      .ok_o    (bcd_dec[b])
    );
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    // apb answer one cycle into the access phase
    if (access && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !addr_hit;
      state_next.prdata  = addr_hit ? {24'h000000, state_reg.rec[slot]}
                                    : 32'h00000000;
    end else begin
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;
    end
    // software write, reserved bits forced low
    for (int i = 0; i < ts_record_pkg::NUM_REGS; i++) begin
      if (wr_slot_hit[i]) begin
        state_next.rec[i] = pwdata_i[7:0] & ts_record_pkg::WR_MASK[i];
      end
    end
    // capture of record one wins over a write
    if (capture1_i) begin
      state_next.rec[ts_record_pkg::SLOT_MIN] = snapshot_i.min
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_MIN];
      state_next.rec[ts_record_pkg::SLOT_HOUR] = snapshot_i.hour
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_HOUR];
      state_next.rec[ts_record_pkg::SLOT_DATE] = snapshot_i.date
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_DATE];
      state_next.rec[ts_record_pkg::SLOT_MONTH] = snapshot_i.month
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_MONTH];
      state_next.rec[ts_record_pkg::SLOT_YEAR] = snapshot_i.year
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_YEAR];
      // trigger source flags
      state_next.rec[ts_record_pkg::SLOT_TRIGGER] = 8'h00;
      state_next.rec[ts_record_pkg::SLOT_TRIGGER]
        [ts_record_pkg::LOW_BACKUP_TRIGGER_FLAG_BIT] =
        source_i.low_backup;
      state_next.rec[ts_record_pkg::SLOT_TRIGGER]
        [ts_record_pkg::TO_BACKUP_TRIGGER_FLAG_BIT] =
        source_i.to_backup;
      state_next.rec[ts_record_pkg::SLOT_TRIGGER]
        [ts_record_pkg::TO_MAIN_TRIGGER_FLAG_BIT] =
        source_i.to_main;
      state_next.rec[ts_record_pkg::SLOT_TRIGGER]
        [ts_record_pkg::EVENT_INPUT_TRIGGER_FLAG_BIT] =
        source_i.event_input;
    end
    // capture of record two head
    if (capture2_i) begin
      state_next.rec[ts_record_pkg::SLOT_SUBSEC] = snapshot_i.subsec
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_SUBSEC];
      state_next.rec[ts_record_pkg::SLOT_SEC] = snapshot_i.sec
        & ts_record_pkg::WR_MASK[ts_record_pkg::SLOT_SEC];
    end
    // decoded views, one cycle behind storage
    state_next.hour   = hour_dec;
    state_next.bcd_ok = bcd_dec;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs, straight from flops
  // ****************************************************************
  assign pready_o       = state_reg.pready;
  assign prdata_o       = state_reg.prdata;
  assign pslverr_o      = state_reg.pslverr;
  assign record_bytes_o = state_reg.rec;
  assign hour_info_o    = state_reg.hour;
  assign bcd_ok_o       = state_reg.bcd_ok;

  // ****************************************************************
  // assertion helpers
  // ****************************************************************
  logic [5:0] exp_hour_bcd; // expected hour from tens and units
  assign exp_hour_bcd = (state_reg.rec[1][4] ? 6'h0a : 6'h00)
                      + {2'b00, state_reg.rec[1][3:0]};

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_hour_mode;
    (wr_slot_hit[1] && !capture1_i) |=> ##1
      (hour_info_o.mode12 == $past(pwdata_i[6], 2));
  endproperty
  a_hour_mode: assert property (p_hour_mode)
    else $error("hour mode view does not follow bit 6");

  property p_pm_view;
    (state_reg.rec[1][6:5] == 2'b11) |=>
      hour_info_o.pm && (!hour_info_o.ok || hour_info_o.hour24 >= 5'd12);
  endproperty
  a_pm_view: assert property (p_pm_view)
    else $error("pm bit not shown as afternoon");

  property p_twenty;
    (state_reg.rec[1][6:4] == 3'b010 && state_reg.rec[1][3:0] <= 4'h3)
      |=> hour_info_o.ok && !hour_info_o.pm
          && (hour_info_o.hour24 >= 5'd20);
  endproperty
  a_twenty: assert property (p_twenty)
    else $error("24-hour bit 5 not weighed as twenty");

  property p_tens_units;
    // reset_n_i keeps out the release edge, where the view is still zero
    (reset_n_i && state_reg.rec[1][6:5] == 2'b00
      && state_reg.rec[1][3:0] <= 4'h9)
      |=> hour_info_o.ok
          && (hour_info_o.hour24 == $past(exp_hour_bcd[4:0]));
  endproperty
  a_tens_units: assert property (p_tens_units)
    else $error("hour tens and units decoded wrong");

  property p_low_flag;
    capture1_i |=> record_bytes_o[5][3] == $past(source_i.low_backup);
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("low backup flag not captured");

  property p_to_backup_flag;
    capture1_i |=> record_bytes_o[5][2] == $past(source_i.to_backup);
  endproperty
  a_to_backup_flag: assert property (p_to_backup_flag)
    else $error("main to backup flag not captured");

  property p_to_main_flag;
    capture1_i |=> record_bytes_o[5][1] == $past(source_i.to_main);
  endproperty
  a_to_main_flag: assert property (p_to_main_flag)
    else $error("backup to main flag not captured");

  property p_event_flag;
    capture1_i |=> (record_bytes_o[5][0] == $past(source_i.event_input))
                   && (record_bytes_o[5][7:4] == 4'h0);
  endproperty
  a_event_flag: assert property (p_event_flag)
    else $error("event input flag not captured");

  property p_min_write;
    (wr_slot_hit[0] && !capture1_i) |=>
      record_bytes_o[0] == ($past(pwdata_i[7:0]) & 8'h7f);
  endproperty
  a_min_write: assert property (p_min_write)
    else $error("minutes write not stored masked");

  property p_subsec;
    capture2_i |=>
      record_bytes_o[6] == {1'b0, $past(snapshot_i.subsec[6:0])};
  endproperty
  a_subsec: assert property (p_subsec)
    else $error("sub-second byte not seven fraction bits");

  property p_apb_answer;
    (access && !state_reg.pready) |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not a single cycle");

  // ****************************************************************
  // apb answer contents and capture of seconds, date and year
  // ****************************************************************
  property p_unmapped_err;
    (access && !state_reg.pready && !addr_hit) |=>
      pready_o && pslverr_o && (prdata_o == 32'h00000000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");

  property p_unmapped_keep;
    (access && state_reg.pready && !addr_hit
      && !capture1_i && !capture2_i) |=>
      record_bytes_o == $past(record_bytes_o);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep)
    else $error("unmapped write changed a stored byte");

  property p_read_data;
    (access && !state_reg.pready && addr_hit) |=>
      pready_o && !pslverr_o
      && (prdata_o == {24'h000000, $past(record_bytes_o[slot])});
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("mapped read data or answer wrong");

  property p_sec_capture;
    capture2_i |=>
      record_bytes_o[7] == ($past(snapshot_i.sec) & 8'h7f);
  endproperty
  a_sec_capture: assert property (p_sec_capture)
    else $error("seconds byte not captured as bcd");

  property p_date_capture;
    capture1_i |=>
      record_bytes_o[2] == ($past(snapshot_i.date) & 8'h3f);
  endproperty
  a_date_capture: assert property (p_date_capture)
    else $error("date byte not captured");

  property p_year_capture;
    capture1_i |=> record_bytes_o[4] == $past(snapshot_i.year);
  endproperty
  a_year_capture: assert property (p_year_capture)
    else $error("year byte not captured");

endmodule // ts_record_regs

// file: bench/event_timestamp_record_regs_tb.sv
`timescale 1ns/1ps
// one compare: counts it, reports a mismatch at once
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp=%h got=%h", nm, ex, got); \
  end end

module event_timestamp_record_regs_tb;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic                          core_clk_i     = 1'b0; // 25 MHz
  logic                          reset_n_i      = 1'b0; // async, low
  logic                          psel_i         = 1'b0; // apb select
  logic                          penable_i      = 1'b0; // apb access
  logic                          pwrite_i       = 1'b0; // apb direction
  logic [11:0]                   paddr_i        = 12'h000;
  logic [31:0]                   pwdata_i       = 32'h0000_0000;
  logic                          pready_o;
  logic [31:0]                   prdata_o;
  logic                          pslverr_o;
  logic                          capture1_i     = 1'b0; // record1 load
  logic                          capture2_i     = 1'b0; // record2 load
  ts_record_pkg::time_snapshot_t snapshot_i     = '0;
  ts_record_pkg::trigger_src_t   source_i       = '0;
  logic [7:0][7:0]               record_bytes_o;
  ts_record_pkg::hour_info_t     hour_info_o;
  logic [4:0]                    bcd_ok_o;
  int                            n_mismatch     = 0;  // failed compares
  int                            num_checks     = 0;  // all compares
  int                            cycles         = 0;  // timeout counter
  logic [31:0]                   rd;                  // read data seen
  logic                          er;                  // slave error seen

  // clock: half period 20 ns
  always #20 core_clk_i = ~core_clk_i;

  ts_record_regs ts_record_regs_i (
    .core_clk_i     (core_clk_i),
    .reset_n_i      (reset_n_i),
    .psel_i         (psel_i),
    .penable_i      (penable_i),
    .pwrite_i       (pwrite_i),
    .paddr_i        (paddr_i),
    .pwdata_i       (pwdata_i),
    .pready_o       (pready_o),
    .prdata_o       (prdata_o),
    .pslverr_o      (pslverr_o),
    .capture1_i     (capture1_i),
    .capture2_i     (capture2_i),
    .snapshot_i     (snapshot_i),
    .source_i       (source_i),
    .record_bytes_o (record_bytes_o),
    .hour_info_o    (hour_info_o),
    .bcd_ok_o       (bcd_ok_o)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // byte address of a register index
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= {24'h00_0000, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge core_clk_i);
      k++;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // one wait state: answer one edge after the first access edge
    `CHK("apb wait states", 1, k)
  endtask

  // write, then let storage and decoded views settle
  task automatic wr_settle(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, ad(idx), d);
    repeat (3) @(posedge core_clk_i);
  endtask

  // ****************************************************************
  // hour and bcd tables: index, byte, expected view
  // ****************************************************************
  localparam int NH = 8;
  localparam logic [7:0] HB [NH] = '{8'h23, 8'h19, 8'h09, 8'h52,
                                     8'h72, 8'h71, 8'h41, 8'h1a};
  // {mode12, pm, hour24, ok}
  localparam logic [7:0] HX [NH] = '{{2'b00, 5'd23, 1'b1},
    {2'b00, 5'd19, 1'b1}, {2'b00, 5'd9, 1'b1}, {2'b10, 5'd0, 1'b1},
    {2'b11, 5'd12, 1'b1}, {2'b11, 5'd23, 1'b1}, {2'b10, 5'd1, 1'b1},
    {2'b00, 5'd0, 1'b0}};
  localparam int NB = 4;
  localparam logic [7:0] BI [NB] = '{8'h2a, 8'h2a, 8'h2d, 8'h2d};
  localparam logic [7:0] BV [NB] = '{8'h59, 8'h5a, 8'h12, 8'h13};
  localparam int         BK [NB] = '{0, 0, 3, 3};
  localparam logic       BE [NB] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // unmapped, misaligned and out-of-window byte addresses
  localparam logic [11:0] UA [3] = '{12'h0c8, 12'h0a9, 12'h4a8};

  // hang guard
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    // reset values of stored bytes, registers and decoded views
    `CHK("bcd_ok reset", 5'h1f, bcd_ok_o)
    `CHK("hour_info reset", 8'h01, hour_info_o)
    for (int i = 0; i < ts_record_pkg::NUM_REGS; i++) begin
      `CHK("byte reset", 8'h00, record_bytes_o[i])
      apb(1'b0, ad(ts_record_pkg::IDX_BASE + 8'(i)), 8'h00);
      `CHK("reg reset", 32'h0000_0000, rd)
    end
    // all ones: reserved bits dropped, fields kept
    for (int i = 0; i < ts_record_pkg::NUM_REGS; i++) begin
      apb(1'b1, ad(ts_record_pkg::IDX_BASE + 8'(i)), 8'hff);
      apb(1'b0, ad(ts_record_pkg::IDX_BASE + 8'(i)), 8'h00);
      `CHK("masked read", {24'h0, ts_record_pkg::WR_MASK[i]}, rd)
      `CHK("read err", 1'b0, er)
    end
    // unmapped, misaligned and out-of-window addresses refused
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, UA[i], 8'h00);
      `CHK("unmapped wr err", 1'b1, er)
      apb(1'b0, UA[i], 8'h00);
      `CHK("unmapped rd err", 1'b1, er)
      `CHK("unmapped rd data", 32'h0000_0000, rd)
    end
    repeat (2) @(posedge core_clk_i);
    `CHK("minutes kept", 8'h7f, record_bytes_o[0])
    // hour byte decoding in both formats
    for (int i = 0; i < NH; i++) begin
      wr_settle(ts_record_pkg::IDX_R1_HOURS, HB[i]);
      `CHK("hour byte", HB[i], record_bytes_o[1])
      `CHK("hour view", HX[i], hour_info_o)
    end
    // bcd range of minutes and month
    for (int i = 0; i < NB; i++) begin
      wr_settle(BI[i], BV[i]);
      `CHK("bcd ok", BE[i], bcd_ok_o[BK[i]])
    end
    // record1 capture, one trigger source at a time
    for (int b = 0; b < 4; b++) begin
      @(posedge core_clk_i);
      capture1_i <= 1'b1;
      snapshot_i <= '{subsec: 8'h00, sec: 8'h00, min: 8'h45,
                      hour: 8'h71, date: 8'h31, month: 8'h92,
                      year: 8'h99};
      source_i   <= 4'(1 << b);
      @(posedge core_clk_i);
      capture1_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      `CHK("cap flags", 8'(1 << b), record_bytes_o[5])
      `CHK("cap min", 8'h45, record_bytes_o[0])
      `CHK("cap month", 8'h92, record_bytes_o[3])
      `CHK("cap date", 8'h31, record_bytes_o[2])
      `CHK("cap hour view", HX[5], hour_info_o)
      apb(1'b0, ad(ts_record_pkg::IDX_R1_TRIGGER), 8'h00);
      `CHK("flags read", {24'h0, 8'(1 << b)}, rd)
    end
    // record2 capture: seven fraction bits, bcd seconds
    @(posedge core_clk_i);
    capture2_i <= 1'b1;
    snapshot_i <= '{subsec: 8'hff, sec: 8'h59, min: 8'h00, hour: 8'h00,
                    date: 8'h00, month: 8'h00, year: 8'h00};
    @(posedge core_clk_i);
    capture2_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CHK("cap subsec", 8'h7f, record_bytes_o[6])
    `CHK("cap sec", 8'h59, record_bytes_o[7])
    `CHK("cap1 untouched", 8'h45, record_bytes_o[0])
    apb(1'b0, ad(ts_record_pkg::IDX_R2_SUBSEC), 8'h00);
    `CHK("subsec read", 32'h0000_007f, rd)
    summarize();
  end

endmodule // event_timestamp_record_regs_tb
